// >>> hdl/rtc_control_status_regs.v
`timescale 1ns/1ns
`include "rtc_regs.vh"

module rtc_control_status_regs (
  input  wire       clk,
  input  wire       reset,
  input  wire       ioSelData,
  input  wire       ioWrite,
  input  wire       ioRead,
  input  wire [7:0] ioWrData,
  output reg  [7:0] ioRdData,
  output wire       irqOut,
  input  wire       batteryOk
);

  // --------------------------------------------------------------------
  // Conversions between internal binary and presented form.
  // --------------------------------------------------------------------
  function [7:0] toExt;
    input [6:0] v;
    input       bin;
    reg   [6:0] tens;
    reg   [6:0] ones;
    begin
      tens = v / 7'd10;
      ones = v % 7'd10;
      if (bin)
        toExt = {1'b0, v};
      else
        toExt = {tens[3:0], ones[3:0]};
    end
  endfunction

  function [6:0] fromExt;
    input [7:0] e;
    input       bin;
    begin
      if (bin)
        fromExt = e[6:0];
      else
        fromExt = e[6:4] * 7'd10 + {3'h0, e[3:0]};
    end
  endfunction

  function [7:0] hourToExt;
    input [6:0] h;
    input       bin;
    input       h24;
    reg   [6:0] h12;
    reg   [7:0] e12;
    begin
      h12 = h % 7'd12;
      e12 = toExt((h12 == 7'd0) ? 7'd12 : h12, bin);
      // In 12-hour form bit 7 flags the afternoon and 12 stands for hour 0.
      if (h24)
        hourToExt = toExt(h, bin);
      else
        hourToExt = {(h >= 7'd12), e12[6:0]};
    end
  endfunction

  function [6:0] hourFromExt;
    input [7:0] e;
    input       bin;
    input       h24;
    reg   [6:0] v;
    begin
      v = fromExt({1'b0, e[6:0]}, bin);
      if (h24)
        hourFromExt = fromExt(e, bin);
      else
        hourFromExt = ((v == 7'd12) ? 7'd0 : v) + (e[7] ? 7'd12 : 7'd0);
    end
  endfunction

  function [6:0] daysIn;
    input [6:0] month;
    input [6:0] year;
    begin
      case (month)
        7'd2:    daysIn = (year[1:0] == 2'h0) ? 7'd29 : 7'd28;
        7'd4,
        7'd6,
        7'd9,
        7'd11:   daysIn = 7'd30;
        default: daysIn = 7'd31;
      endcase
    end
  endfunction

  function almMatch;
    input [7:0] alarm;
    input [7:0] now;
    begin
      almMatch = (alarm[7:6] == `RTC_ALM_ANY) || (alarm == now);
    end
  endfunction

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg  [6:0]  index_reg;
  reg  [6:0]  ctrlA_reg;
  reg  [7:0]  ctrlB_reg;
  reg         flagP_reg;
  reg         flagA_reg;
  reg         flagU_reg;
  reg         lost_reg;
  reg         battMeta_reg;
  reg         battSync_reg;
  reg  [24:0] acc_reg;
  reg  [14:0] div_reg;
  reg  [6:0]  sec_reg;
  reg  [6:0]  min_reg;
  reg  [6:0]  hour_reg;
  reg  [2:0]  dow_reg;
  reg  [6:0]  dom_reg;
  reg  [6:0]  month_reg;
  reg  [6:0]  year_reg;
  reg  [7:0]  secAlm_reg;
  reg  [7:0]  minAlm_reg;
  reg  [7:0]  hourAlm_reg;
  reg         fallDone_reg;
  reg  [7:0]  mem [0:127];

  reg  [7:0]  rdValue;
  reg  [14:0] rateMask;
  reg  [3:0]  rateExp;

  wire [24:0] accSum   = acc_reg + `RTC_BASE_HZ;
  wire        baseHit  = (accSum >= `RTC_CLK_HZ);
  wire [2:0]  divCtl   = ctrlA_reg[6:4];
  wire        divRun   = (divCtl == `RTC_DIV_RUN);
  wire        divHold  = (divCtl[2:1] == 2'h3);
  wire        tick     = baseHit && divRun;
  wire        secEdge  = tick && (div_reg == 15'h7fff);
  wire        halted   = ctrlB_reg[`RTC_B_HALT];
  wire        doUpdate = secEdge && !halted;
  wire        binMode  = ctrlB_reg[`RTC_B_BIN];
  wire        h24Mode  = ctrlB_reg[`RTC_B_H24];
  wire        dataWr   = ioWrite && ioSelData;
  wire        dataRd   = ioRead && ioSelData;
  wire        perHit;
  wire        almHit;
  wire        uip;

  // --------------------------------------------------------------------
  // Periodic rate decode.
  // --------------------------------------------------------------------
  // Codes 1 and 2 repeat the slower intervals of codes 8 and 9.
  always @* begin
    case (ctrlA_reg[3:0])
      4'h1:    rateExp = 4'h7;
      4'h2:    rateExp = 4'h8;
      default: rateExp = ctrlA_reg[3:0] - 4'h1;
    endcase
    rateMask = (15'h1 << rateExp) - 15'h1;
  end

  assign perHit = tick && (ctrlA_reg[3:0] != 4'h0)
                  && ((div_reg & rateMask) == rateMask);
  assign uip    = divRun && !halted
                  && (div_reg >= (15'h7fff - `RTC_UIP_TICKS));

  assign almHit = almMatch(secAlm_reg, toExt(sec_reg, binMode))
                  && almMatch(minAlm_reg, toExt(min_reg, binMode))
                  && almMatch(hourAlm_reg, hourToExt(hour_reg, binMode, h24Mode));

  assign irqOut = (flagP_reg && ctrlB_reg[`RTC_B_PIE])
                  || (flagA_reg && ctrlB_reg[`RTC_B_AIE])
                  || (flagU_reg && ctrlB_reg[`RTC_B_UIE]);

  // --------------------------------------------------------------------
  // Host index port and read data.
  // --------------------------------------------------------------------
  // The index keeps only seven bits; the top bit written is ignored.
  always @* begin
    case (index_reg)
      `RTC_LOC_SEC:      rdValue = toExt(sec_reg, binMode);
      `RTC_LOC_SEC_ALM:  rdValue = secAlm_reg;
      `RTC_LOC_MIN:      rdValue = toExt(min_reg, binMode);
      `RTC_LOC_MIN_ALM:  rdValue = minAlm_reg;
      `RTC_LOC_HOUR:     rdValue = hourToExt(hour_reg, binMode, h24Mode);
      `RTC_LOC_HOUR_ALM: rdValue = hourAlm_reg;
      `RTC_LOC_DOW:      rdValue = {5'h00, dow_reg};
      `RTC_LOC_DOM:      rdValue = toExt(dom_reg, binMode);
      `RTC_LOC_MONTH:    rdValue = toExt(month_reg, binMode);
      `RTC_LOC_YEAR:     rdValue = toExt(year_reg, binMode);
      `RTC_LOC_CTRL_A:   rdValue = {uip, ctrlA_reg};
      `RTC_LOC_CTRL_B:   rdValue = ctrlB_reg;
      `RTC_LOC_STAT_C:   rdValue = {irqOut, flagP_reg, flagA_reg, flagU_reg, 4'h0};
      `RTC_LOC_STAT_D:   rdValue = {battSync_reg && !lost_reg, 7'h00};
      default:           rdValue = mem[index_reg];
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      index_reg <= 7'h00;
      ioRdData  <= 8'h00;
    end else begin
      if (ioWrite && !ioSelData)
        index_reg <= ioWrData[6:0];
      if (dataRd)
        ioRdData <= rdValue;
    end
  end

  // Plain storage above the clock locations.
  always @(posedge clk) begin
    if (dataWr && (index_reg > `RTC_LOC_STAT_D))
      mem[index_reg] <= ioWrData;
  end

  // --------------------------------------------------------------------
  // Control bytes, flags and power status.
  // --------------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrlA_reg    <= `RTC_A_RESET;
      ctrlB_reg    <= `RTC_B_RESET;
      flagP_reg    <= 1'b0;
      flagA_reg    <= 1'b0;
      flagU_reg    <= 1'b0;
      lost_reg     <= 1'b1;
      battMeta_reg <= 1'b0;
      battSync_reg <= 1'b0;
    end else begin
      battMeta_reg <= batteryOk;
      battSync_reg <= battMeta_reg;
      if (dataWr && (index_reg == `RTC_LOC_CTRL_A))
        ctrlA_reg <= ioWrData[6:0];
      if (dataWr && (index_reg == `RTC_LOC_CTRL_B))
        ctrlB_reg <= ioWrData & `RTC_B_MASK;
      // Reading status C clears flags, but an event in the same cycle wins.
      if (dataRd && (index_reg == `RTC_LOC_STAT_C)) begin
        flagP_reg <= perHit;
        flagA_reg <= doUpdate && almHit;
        flagU_reg <= doUpdate;
      end else begin
        flagP_reg <= flagP_reg || perHit;
        flagA_reg <= flagA_reg || (doUpdate && almHit);
        flagU_reg <= flagU_reg || doUpdate;
      end
      // The loss latch stays set while backup power is low, whatever is read.
      if (!battSync_reg)
        lost_reg <= 1'b1;
      else if (dataRd && (index_reg == `RTC_LOC_STAT_D))
        lost_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Time base and divider chain.
  // --------------------------------------------------------------------
  // The accumulator spreads the base ticks evenly over the clocks of a second.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_reg <= 25'h0000000;
      div_reg <= 15'h0000;
    end else if (divHold) begin
      acc_reg <= 25'h0000000;
      div_reg <= 15'h0000;
    end else if (divRun) begin
      acc_reg <= baseHit ? (accSum - `RTC_CLK_HZ) : accSum;
      if (tick)
        div_reg <= div_reg + 15'h0001;
    end
  end

  // --------------------------------------------------------------------
  // Time and date counters.
  // --------------------------------------------------------------------
  // A host write to a time, date or alarm location wins over an update that falls in the same cycle.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sec_reg      <= 7'h00;
      min_reg      <= 7'h00;
      hour_reg     <= 7'h00;
      dow_reg      <= 3'h1;
      dom_reg      <= 7'h01;
      month_reg    <= 7'h01;
      year_reg     <= 7'h00;
      secAlm_reg   <= 8'h00;
      minAlm_reg   <= 8'h00;
      hourAlm_reg  <= 8'h00;
      fallDone_reg <= 1'b0;
    end else if (dataWr && (index_reg < `RTC_LOC_CTRL_A)) begin
      case (index_reg)
        `RTC_LOC_SEC:      sec_reg     <= fromExt(ioWrData, binMode);
        `RTC_LOC_SEC_ALM:  secAlm_reg  <= ioWrData;
        `RTC_LOC_MIN:      min_reg     <= fromExt(ioWrData, binMode);
        `RTC_LOC_MIN_ALM:  minAlm_reg  <= ioWrData;
        `RTC_LOC_HOUR:     hour_reg    <= hourFromExt(ioWrData, binMode, h24Mode);
        `RTC_LOC_HOUR_ALM: hourAlm_reg <= ioWrData;
        `RTC_LOC_DOW:      dow_reg     <= ioWrData[2:0];
        `RTC_LOC_DOM:      dom_reg     <= fromExt(ioWrData, binMode);
        `RTC_LOC_MONTH:    month_reg   <= fromExt(ioWrData, binMode);
        default:           year_reg    <= fromExt(ioWrData, binMode);
      endcase
    end else if (doUpdate) begin
      if (month_reg != 7'd10)
        fallDone_reg <= 1'b0;
      if (sec_reg != 7'd59) begin
        sec_reg <= sec_reg + 7'd1;
      end else begin
        sec_reg <= 7'd0;
        if (min_reg != 7'd59) begin
          min_reg <= min_reg + 7'd1;
        end else begin
          min_reg <= 7'd0;
          if (ctrlB_reg[`RTC_B_DST] && (hour_reg == 7'd1) && (dow_reg == 3'h1)
              && (month_reg == 7'd4) && (dom_reg <= 7'd7)) begin
            hour_reg <= 7'd3;
          end else if (ctrlB_reg[`RTC_B_DST] && (hour_reg == 7'd1) && (dow_reg == 3'h1)
                       && (month_reg == 7'd10) && (dom_reg >= 7'd25) && !fallDone_reg) begin
            hour_reg     <= 7'd1;
            fallDone_reg <= 1'b1;
          end else if (hour_reg != 7'd23) begin
            hour_reg <= hour_reg + 7'd1;
          end else begin
            hour_reg <= 7'd0;
            dow_reg  <= (dow_reg == 3'h7) ? 3'h1 : dow_reg + 3'h1;
            if (dom_reg < daysIn(month_reg, year_reg)) begin
              dom_reg <= dom_reg + 7'd1;
            end else begin
              dom_reg <= 7'd1;
              if (month_reg != 7'd12) begin
                month_reg <= month_reg + 7'd1;
              end else begin
                month_reg <= 7'd1;
                year_reg  <= (year_reg == 7'd99) ? 7'd0 : year_reg + 7'd1;
              end
            end
          end
        end
      end
    end
  end

endmodule // rtc_control_status_regs

// >>> hdl/rtc_regs.vh
`ifndef RTC_REGS_VH
`define RTC_REGS_VH

// ----------------------------------------------------------------------
// Locations
// ----------------------------------------------------------------------
`define RTC_LOC_SEC      7'h00
`define RTC_LOC_SEC_ALM  7'h01
`define RTC_LOC_MIN      7'h02
`define RTC_LOC_MIN_ALM  7'h03
`define RTC_LOC_HOUR     7'h04
`define RTC_LOC_HOUR_ALM 7'h05
`define RTC_LOC_DOW      7'h06
`define RTC_LOC_DOM      7'h07
`define RTC_LOC_MONTH    7'h08
`define RTC_LOC_YEAR     7'h09
`define RTC_LOC_CTRL_A   7'h0a
`define RTC_LOC_CTRL_B   7'h0b
`define RTC_LOC_STAT_C   7'h0c
`define RTC_LOC_STAT_D   7'h0d

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RTC_A_UIP      7
`define RTC_B_HALT     7
`define RTC_B_PIE      6
`define RTC_B_AIE      5
`define RTC_B_UIE      4
`define RTC_B_BIN      2
`define RTC_B_H24      1
`define RTC_B_DST      0
`define RTC_C_IRQ      7
`define RTC_C_PF       6
`define RTC_C_AF       5
`define RTC_C_UF       4
`define RTC_D_VALID    7
`define RTC_DIV_RUN    3'h2
`define RTC_B_MASK     8'hf7

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define RTC_A_RESET    7'h26
`define RTC_B_RESET    8'h02
`define RTC_CLK_HZ     25'd20000000
`define RTC_BASE_HZ    25'd32768
`define RTC_UIP_US     2444
`define RTC_UIP_TICKS  ((`RTC_UIP_US * 32768) / 1000000)
`define RTC_ALM_ANY    2'h3

`endif

// >>> verif/rtc_control_status_regs_properties.sv
`timescale 1ns/1ns

module rtc_control_status_regs_checker (
  input wire       clk,
  input wire       reset,
  input wire       ioSelData,
  input wire       ioWrite,
  input wire       ioRead,
  input wire [7:0] ioWrData,
  input wire [7:0] ioRdData,
  input wire       irqOut,
  input wire       batteryOk
);
  logic [6:0] locIndex_reg;
  logic [6:0] shadowA_reg;
  logic [7:0] shadowB_reg;
  wire        rdData = ioRead && ioSelData;
  wire        wrData = ioWrite && ioSelData;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // --------------------------------------------------------------
  // Shadow of the index and of the writable control bytes.
  // --------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      locIndex_reg <= 7'h00;
      shadowA_reg  <= 7'h26;
      shadowB_reg  <= 8'h02;
    end else begin
      if (ioWrite && !ioSelData) locIndex_reg <= ioWrData[6:0];
      if (wrData && locIndex_reg == 7'h0a) shadowA_reg <= ioWrData[6:0];
      if (wrData && locIndex_reg == 7'h0b) shadowB_reg <= ioWrData & 8'hf7;
    end
  end

  // --------------------------------------------------------------
  // Port behaviour.
  // --------------------------------------------------------------
  a_reset_quiet: assert property ($fell(reset) |-> ioRdData == 8'h00 && !irqOut)
    else $error("outputs not quiet after reset");
  a_read_holds: assert property (!rdData |=> $stable(ioRdData))
    else $error("read data changed without a read");
  a_status_c_bits: assert property (rdData && locIndex_reg == 7'h0c |=>
    ioRdData[7] == $past(irqOut) && ioRdData[3:0] == 4'h0)
    else $error("status C bits wrong");
  a_ctrl_a_readback: assert property (rdData && locIndex_reg == 7'h0a |=>
    ioRdData[6:0] == $past(shadowA_reg))
    else $error("control A readback wrong");
  a_ctrl_b_readback: assert property (rdData && locIndex_reg == 7'h0b |=>
    ioRdData == $past(shadowB_reg))
    else $error("control B readback wrong");
  a_status_d_bits: assert property (rdData && locIndex_reg == 7'h0d |=>
    ioRdData[6:0] == 7'h00)
    else $error("status D reserved bits set");
  a_power_lost: assert property ((!batteryOk) [*3] ##1
    (!batteryOk && rdData && locIndex_reg == 7'h0d) |=> !ioRdData[7])
    else $error("power loss not reported");
  a_irq_gated: assert property (shadowB_reg[6:4] == 3'h0 |-> !irqOut)
    else $error("interrupt raised with all enables off");
endmodule // rtc_control_status_regs_checker

bind rtc_control_status_regs rtc_control_status_regs_checker rtc_control_status_regs_checker_inst (
  .clk(clk), .reset(reset), .ioSelData(ioSelData), .ioWrite(ioWrite), .ioRead(ioRead),
  .ioWrData(ioWrData), .ioRdData(ioRdData), .irqOut(irqOut), .batteryOk(batteryOk));

// >>> verif/rtc_host_model.sv
`timescale 1ns/1ns

module rtc_host_model (
  input  wire        clk,
  input  wire  [7:0] ioRdData,
  output logic       ioSelData,
  output logic       ioWrite,
  output logic       ioRead,
  output logic [7:0] ioWrData
);
  initial begin
    ioSelData = 1'b0;
    ioWrite   = 1'b0;
    ioRead    = 1'b0;
    ioWrData  = 8'h00;
  end

  // --------------------------------------------------------------
  // Index cycle followed by one data cycle; the data lines are
  // inverted once released so a stale value never looks valid.
  // --------------------------------------------------------------
  task automatic hostWrite(input logic [7:0] loc, input logic [7:0] data);
    @(posedge clk);
    #1;
    ioSelData = 1'b0;
    ioWrite   = 1'b1;
    ioWrData  = loc;
    @(posedge clk);
    #1;
    ioSelData = 1'b1;
    ioWrData  = data;
    @(posedge clk);
    #1;
    ioWrite  = 1'b0;
    ioWrData = ~data;
  endtask

  task automatic hostRead(input logic [7:0] loc, output logic [7:0] data);
    @(posedge clk);
    #1;
    ioSelData = 1'b0;
    ioWrite   = 1'b1;
    ioWrData  = loc;
    @(posedge clk);
    #1;
    ioWrite   = 1'b0;
    ioWrData  = ~loc;
    ioSelData = 1'b1;
    ioRead    = 1'b1;
    @(posedge clk);
    #1;
    ioRead = 1'b0;
    @(posedge clk);
    #1;
    data = ioRdData;
  endtask
endmodule // rtc_host_model

// >>> verif/tb_rtc_control_status_regs.sv
`timescale 1ns/1ns

module tb_rtc_control_status_regs;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       batteryOk = 1'b1;
  wire        ioSelData;
  wire        ioWrite;
  wire        ioRead;
  wire  [7:0] ioWrData;
  wire  [7:0] ioRdData;
  wire        irqOut;
  int         fails = 0;
  int         checks_done = 0;

  always #25 clk = ~clk;

  rtc_control_status_regs rtc_control_status_regs_inst (
    .clk(clk), .reset(reset), .ioSelData(ioSelData), .ioWrite(ioWrite), .ioRead(ioRead),
    .ioWrData(ioWrData), .ioRdData(ioRdData), .irqOut(irqOut), .batteryOk(batteryOk));

  rtc_host_model rtc_host_model_inst (
    .clk(clk), .ioRdData(ioRdData), .ioSelData(ioSelData), .ioWrite(ioWrite),
    .ioRead(ioRead), .ioWrData(ioWrData));

  // --------------------------------------------------------------
  // Shared helpers.
  // --------------------------------------------------------------
  task automatic print_verdict();
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdChk(input logic [7:0] loc, input logic [7:0] exp);
    logic [7:0] got;
    rtc_host_model_inst.hostRead(loc, got);
    check(got, exp);
  endtask

  task automatic wr(input logic [7:0] loc, input logic [7:0] data);
    rtc_host_model_inst.hostWrite(loc, data);
  endtask

  task automatic waitIrq(input int lim, output int n);
    n = 0;
    while (irqOut !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= lim) begin
      fails++;
      $display("BAD %0t no interrupt", $time);
      print_verdict();
    end
  endtask

  // --------------------------------------------------------------
  // Scenarios.
  // --------------------------------------------------------------
  task automatic scnResetAndPower();
    rdChk(8'h0a, 8'h26);
    rdChk(8'h0b, 8'h02);
    rdChk(8'h0c, 8'h00);
    rdChk(8'h0d, 8'h00);
    rdChk(8'h0d, 8'h80);
    wr(8'h0d, 8'h00);
    rdChk(8'h0d, 8'h80);
    batteryOk = 1'b0;
    repeat (4) @(posedge clk);
    rdChk(8'h0d, 8'h00);
    batteryOk = 1'b1;
    repeat (4) @(posedge clk);
    rdChk(8'h0d, 8'h00);
    rdChk(8'h0d, 8'h80);
  endtask

  task automatic scnRegisters();
    wr(8'h0b, 8'hff);
    rdChk(8'h0b, 8'hf7);
    wr(8'h0b, 8'h02);
    wr(8'h0a, 8'hff);
    rdChk(8'h0a, 8'h7f);
    wr(8'h0c, 8'hff);
    rdChk(8'h0c, 8'h00);
    wr(8'h8e, 8'ha5);
    rdChk(8'h0e, 8'ha5);
  endtask

  task automatic scnFormats();
    wr(8'h0b, 8'h82);
    wr(8'h00, 8'h59);
    wr(8'h04, 8'h15);
    rdChk(8'h00, 8'h59);
    rdChk(8'h04, 8'h15);
    wr(8'h0b, 8'h86);
    rdChk(8'h00, 8'h3b);
    rdChk(8'h04, 8'h0f);
    wr(8'h00, 8'h2a);
    wr(8'h0b, 8'h80);
    rdChk(8'h00, 8'h42);
    rdChk(8'h04, 8'h83);
    wr(8'h04, 8'h12);
    wr(8'h0b, 8'h82);
    rdChk(8'h04, 8'h00);
    rdChk(8'h0b, 8'h82);
    wr(8'h0b, 8'h02);
  endtask

  task automatic scnNoEvents();
    logic [7:0] modes [5] = '{8'h03, 8'h13, 8'h63, 8'h73, 8'h20};
    wr(8'h0b, 8'h42);
    foreach (modes[i]) begin
      wr(8'h0a, modes[i]);
      repeat (3000) @(posedge clk);
      #1;
      check({7'h00, irqOut}, 8'h00);
      rdChk(8'h0c, 8'h00);
    end
  endtask

  task automatic scnGate();
    wr(8'h0b, 8'h02);
    wr(8'h0a, 8'h23);
    repeat (3000) @(posedge clk);
    #1;
    check({7'h00, irqOut}, 8'h00);
    rdChk(8'h0c, 8'h40);
  endtask

  task automatic scnRates();
    int         n;
    int         p;
    logic [7:0] junk;
    wr(8'h0b, 8'h42);
    for (int code = 3; code <= 5; code++) begin
      p = ((1 << (code - 1)) * 20000000) / 32768;
      wr(8'h0a, 8'h20 | 8'(code));
      rtc_host_model_inst.hostRead(8'h0c, junk);
      waitIrq(2 * p + 50, n);
      rdChk(8'h0c, 8'hc0);
      waitIrq(2 * p, n);
      check({7'h00, (n + 4 >= p - 2) && (n + 4 <= p + 2)}, 8'h01);
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    scnResetAndPower();
    scnRegisters();
    scnFormats();
    scnNoEvents();
    scnGate();
    scnRates();
    print_verdict();
  end
endmodule // tb_rtc_control_status_regs
